/* core/rtcc_pkg.sv */
// Package for the calendar and alarm set-point register block
package rtcc_pkg;
    // ----------------------------------------
    // Register offsets on the I/O bus
    // ----------------------------------------
    localparam logic [7:0] RTCC_ADDR_CAL_PERIOD = 8'hE5;
    localparam logic [7:0] RTCC_ADDR_YEAR = 8'hE6;
    localparam logic [7:0] RTCC_ADDR_HUNDRED_YEAR = 8'hE7;
    localparam logic [7:0] RTCC_ADDR_ALARM_SECOND = 8'hE8;
    localparam logic [7:0] RTCC_ADDR_ALARM_MINUTE = 8'hE9;
    // ----------------------------------------
    // Field positions and count limits
    // ----------------------------------------
    localparam int RTCC_TENS_MSB = 7;
    localparam int RTCC_TENS_LSB = 4;
    localparam int RTCC_ONES_MSB = 3;
    localparam int RTCC_ONES_LSB = 0;
    localparam logic [7:0] RTCC_PERIOD_FIRST = 8'h01;
    localparam logic [7:0] RTCC_PERIOD_LAST = 8'h0C;
    localparam logic [7:0] RTCC_YEAR_LAST = 8'h63;
    localparam logic [7:0] RTCC_ZERO = 8'h00;
    localparam logic [7:0] RTCC_READ_IDLE = 8'h00;

    // Byte seen as two digit fields in BCD mode
    typedef struct packed {
        logic [3:0] tens_digit;
        logic [3:0] ones_digit;
    } rtcc_bcd_t;

    // Time and set-point state; none of it is reset, so read data lives apart
    typedef struct packed {
        logic [7:0] cal_period;
        logic [7:0] year;
        logic [7:0] hundred_year;
        logic [7:0] alarm_second;
        logic [7:0] alarm_minute;
    } rtcc_state_t;
endpackage

/* core/rtcc_calendar_regs.sv */
// Upper calendar counters and alarm second and minute set points
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// ----------------------------------------
module rtcc_calendar_regs
    import rtcc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // CPU I/O bus
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wr_data,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [7:0] io_rd_data,
    // Control from the rest of the clock
    input wire logic bcd_mode,
    input wire logic clock_unlocked,
    input wire logic day_rollover,
    input wire logic alarm_second_en,
    input wire logic alarm_minute_en,
    input wire logic [7:0] current_second,
    input wire logic [7:0] current_minute,
    // Results
    output logic alarm_second_match,
    output logic alarm_minute_match,
    output logic [7:0] cal_period,
    output logic [7:0] year,
    output logic [7:0] hundred_year
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Advance a byte in either coding; bit 8 of the result is the carry out
    // Only the last value wraps, so an illegal value from the CPU walks on; in BCD a ones digit above 9 carries at once
    function automatic logic [8:0] rtcc_incr(input logic [7:0] v, input logic bcd,
                                            input logic [7:0] last, input logic [7:0] first);
        rtcc_bcd_t b;
        logic [7:0] n;
        b = v;
        n = 8'(v + 8'h01);
        // A full ones digit carries into the tens digit
        if (bcd && b.ones_digit >= 4'h9) begin
            n = {4'(b.tens_digit + 4'h1), 4'h0};
        end
        if (v == last) begin
            return {1'b1, first};
        end
        return {1'b0, n};
    endfunction

    // Binary limit converted to the BCD figure when decimal mode is on
    // Limits stay below 100, so two digits always suffice
    function automatic logic [7:0] rtcc_limit(input logic [7:0] bin, input logic bcd);
        logic [7:0] r;
        r = bin;
        if (bcd) begin
            r = {4'(bin / 8'd10), 4'(bin % 8'd10)};
        end
        return r;
    endfunction

    // A disabled set point counts as matching so it never blocks the alarm
    // Shared by the two set points
    function automatic logic rtcc_match(input logic en, input logic [7:0] now,
                                        input logic [7:0] point);
        return !en || (now == point);
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    // Registered state; the read register alone is reset
    rtcc_state_t s_q;
    rtcc_state_t s_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;

    // Count chain
    logic [7:0] period_last;
    logic [7:0] year_last;
    logic [8:0] per_inc;
    logic [8:0] yr_inc;
    logic [8:0] cen_inc;
    logic count_run;
    logic year_step;
    logic hundred_step;

    // Bus strobes
    logic wr_count;
    logic wr_alarm;

    // ----------------------------------------
    // Count chain
    // ----------------------------------------
    // Counting and CPU writes to the counts never meet: one needs the lock closed, the other open
    assign count_run = !clock_unlocked && day_rollover;
    assign year_step = count_run && per_inc[8];
    assign hundred_step = year_step && yr_inc[8];

    // Upper limits follow the coding in use; year and hundred-year share one
    assign period_last = rtcc_limit(RTCC_PERIOD_LAST, bcd_mode);
    assign year_last = rtcc_limit(RTCC_YEAR_LAST, bcd_mode);

    // The hundred-year count wraps after 99, as nothing stands above it
    assign per_inc = rtcc_incr(s_q.cal_period, bcd_mode, period_last, RTCC_PERIOD_FIRST);
    assign yr_inc = rtcc_incr(s_q.year, bcd_mode, year_last, RTCC_ZERO);
    assign cen_inc = rtcc_incr(s_q.hundred_year, bcd_mode, year_last, RTCC_ZERO);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // A write to an unmapped address falls through both decodes and is lost
    assign wr_count = io_wr && clock_unlocked;
    assign wr_alarm = io_wr;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        rd_d = RTCC_READ_IDLE;

        // Month-end step
        if (count_run) begin
            s_d.cal_period = per_inc[7:0];
        end
        if (year_step) begin
            s_d.year = yr_inc[7:0];
        end
        if (hundred_step) begin
            s_d.hundred_year = cen_inc[7:0];
        end

        // Count registers only take CPU data while unlocked
        if (wr_count) begin
            unique case (io_addr)
                RTCC_ADDR_CAL_PERIOD: s_d.cal_period = io_wr_data;
                RTCC_ADDR_YEAR: s_d.year = io_wr_data;
                RTCC_ADDR_HUNDRED_YEAR: s_d.hundred_year = io_wr_data;
                default: ;
            endcase
        end

        // Set points ignore the lock
        if (wr_alarm) begin
            unique case (io_addr)
                RTCC_ADDR_ALARM_SECOND: s_d.alarm_second = io_wr_data;
                RTCC_ADDR_ALARM_MINUTE: s_d.alarm_minute = io_wr_data;
                default: ;
            endcase
        end

        // Idle and unmapped reads return zero
        if (io_rd) begin
            unique case (io_addr)
                RTCC_ADDR_CAL_PERIOD: rd_d = s_q.cal_period;
                RTCC_ADDR_YEAR: rd_d = s_q.year;
                RTCC_ADDR_HUNDRED_YEAR: rd_d = s_q.hundred_year;
                RTCC_ADDR_ALARM_SECOND: rd_d = s_q.alarm_second;
                RTCC_ADDR_ALARM_MINUTE: rd_d = s_q.alarm_minute;
                default: rd_d = RTCC_READ_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Asynchronous reset, so the bus sees idle read data at once
    // Read data is held one cycle, then falls back to zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_q <= RTCC_READ_IDLE;
        end else begin
            rd_q <= rd_d;
        end
    end

    // No reset on purpose: a reset must not lose the calendar counts or the set points
    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    // ----------------------------------------
    // Alarm compare
    // ----------------------------------------
    // Matches are combinational; the current counts come from flops on this clock
    assign alarm_second_match = rtcc_match(alarm_second_en, current_second, s_q.alarm_second);
    assign alarm_minute_match = rtcc_match(alarm_minute_en, current_minute, s_q.alarm_minute);

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Counts leave straight from their flip-flops
    assign io_rd_data = rd_q;
    assign cal_period = s_q.cal_period;
    assign year = s_q.year;
    assign hundred_year = s_q.hundred_year;
endmodule
`default_nettype wire

/* test/rtcc_calendar_regs_assertions.sv */
// Checker for the calendar and alarm register block
`timescale 1ns/1ns
`default_nettype none
module rtcc_calendar_regs_checker (
    // Clock, reset and bus
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wr_data,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_rd_data,
    // Control and results
    input wire logic bcd_mode,
    input wire logic clock_unlocked,
    input wire logic day_rollover,
    input wire logic alarm_second_en,
    input wire logic alarm_second_match,
    input wire logic alarm_minute_en,
    input wire logic alarm_minute_match,
    input wire logic [7:0] cal_period,
    input wire logic [7:0] year,
    input wire logic [7:0] hundred_year
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Counting step with no CPU write in the way
    wire logic roll = day_rollover && !clock_unlocked && !io_wr;
    a_rd_year: assert property (io_rd && !io_wr && io_addr == 8'hE6 |=> io_rd_data == $past(year))
        else $error("year read wrong");
    a_roll_inc: assert property (roll && !bcd_mode && cal_period < 8'h0C |=> cal_period == $past(cal_period) + 8'h01)
        else $error("period step wrong");
    a_period_wrap: assert property (roll && !bcd_mode && cal_period == 8'h0C |=> cal_period == 8'h01)
        else $error("period wrap wrong");
    a_year_wrap: assert property (roll && !bcd_mode && cal_period == 8'h0C && year == 8'h63
        |=> year == 8'h00 && hundred_year == $past(hundred_year) + 8'h01)
        else $error("year wrap wrong");
    a_bcd_wrap: assert property (roll && bcd_mode && cal_period == 8'h12 && year == 8'h99
        |=> cal_period == 8'h01 && year == 8'h00)
        else $error("decimal wrap wrong");
    a_unl_stop: assert property (day_rollover && clock_unlocked && !io_wr |=> $stable(cal_period))
        else $error("counted while unlocked");
    a_lock_keep: assert property (io_wr && !clock_unlocked && !day_rollover && io_addr == 8'hE5
        |=> $stable(cal_period))
        else $error("locked write taken");
    a_unl_write: assert property (io_wr && clock_unlocked && io_addr == 8'hE7 |=> hundred_year == $past(io_wr_data))
        else $error("unlocked write lost");
    a_match_off: assert property (!alarm_second_en |-> alarm_second_match)
        else $error("disabled set point blocks");
    a_min_off: assert property (!alarm_minute_en |-> alarm_minute_match)
        else $error("disabled minute point blocks");
    a_bcd_carry: assert property (roll && bcd_mode && cal_period == 8'h09 |=> cal_period == 8'h10)
        else $error("decimal carry wrong");
    c_bcd_carry: cover property (roll && bcd_mode && cal_period == 8'h09);
    c_wrap: cover property (roll && cal_period == 8'h0C);
    c_bcd: cover property (roll && bcd_mode);
    c_refused: cover property (io_wr && !clock_unlocked && io_addr == 8'hE5);
endmodule
bind rtcc_calendar_regs rtcc_calendar_regs_checker u_chk (.clock, .rst, .io_addr, .io_wr_data, .io_wr, .io_rd,
    .io_rd_data, .bcd_mode, .clock_unlocked, .day_rollover, .alarm_second_en, .alarm_second_match,
    .alarm_minute_en, .alarm_minute_match, .cal_period,
    .year, .hundred_year);
`default_nettype wire

/* test/rtcc_calendar_regs_tb.sv */
// Self-checking bench for the calendar and alarm register block
`timescale 1ns/1ns
`default_nettype none
module rtcc_calendar_regs_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] io_addr = 8'h00, io_wr_data = 8'h00, current_second = 8'h3B, current_minute = 8'h00;
    logic io_wr = 1'b0, io_rd = 1'b0, bcd_mode = 1'b0, clock_unlocked = 1'b0, day_rollover = 1'b0;
    logic alarm_second_en = 1'b0, alarm_minute_en = 1'b0, alarm_second_match, alarm_minute_match;
    logic [7:0] io_rd_data, cal_period, year, hundred_year;
    int fail_count = 0, n_compared = 0, cycles = 0;
    // Rows: unlock, address, write data, expected read back
    logic [27:0] rows [0:6] = '{28'h1E50C0C, 28'h1E66363, 28'h1E70505, 28'h0E83B3B, 28'h0E92D2D, 28'h0E5070C,
        28'h1E3AA00};
    always #25 clock = ~clock;
    rtcc_calendar_regs dut (.clock, .rst, .io_addr, .io_wr_data, .io_wr, .io_rd, .io_rd_data, .bcd_mode,
        .clock_unlocked, .day_rollover, .alarm_second_en, .alarm_minute_en, .current_second, .current_minute,
        .alarm_second_match, .alarm_minute_match, .cal_period, .year, .hundred_year);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // Strobes drop a cycle before the next request, so no signal is set twice at one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock) {io_addr, io_wr_data, io_wr} = {a, d, 1'b1};
        @(negedge clock) io_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock) {io_addr, io_rd} = {a, 1'b1};
        @(negedge clock) io_rd = 1'b0;
        check(io_rd_data, exp);
    endtask
    task automatic roll;
        @(negedge clock) day_rollover = 1'b1;
        @(negedge clock) day_rollover = 1'b0;
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        foreach (rows[i]) begin
            clock_unlocked = rows[i][24];
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        {alarm_second_en, alarm_minute_en, current_minute} = {2'b11, 8'h2D};
        @(negedge clock) check({6'h00, alarm_second_match, alarm_minute_match}, 8'h03);
        current_second = 8'h3A;
        @(negedge clock) check({6'h00, alarm_second_match, alarm_minute_match}, 8'h01);
        {alarm_second_en, current_minute} = {1'b0, 8'h2C};
        @(negedge clock) check({6'h00, alarm_second_match, alarm_minute_match}, 8'h02);
        alarm_minute_en = 1'b0;
        @(negedge clock) check({6'h00, alarm_second_match, alarm_minute_match}, 8'h03);
        roll();
        check(cal_period, 8'h0C);
        clock_unlocked = 1'b0;
        roll();
        check(cal_period, 8'h01);
        check(year, 8'h00);
        check(hundred_year, 8'h06);
        roll();
        check(cal_period, 8'h02);
        {clock_unlocked, bcd_mode} = 2'b11;
        wr(8'hE5, 8'h12);
        wr(8'hE6, 8'h99);
        wr(8'hE7, 8'h19);
        clock_unlocked = 1'b0;
        roll();
        check(cal_period, 8'h01);
        check(year, 8'h00);
        check(hundred_year, 8'h20);
        clock_unlocked = 1'b1;
        wr(8'hE5, 8'h09);
        clock_unlocked = 1'b0;
        roll();
        check(cal_period, 8'h10);
        @(negedge clock) rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        rd(8'hE7, 8'h20);
        rd(8'hE8, 8'h3B);
        wrap_up();
    end
endmodule
`default_nettype wire
